// file: logic/rxc_consts.svh
// offsets, field positions, reset values for receiver config registers
`ifndef RXC_CONSTS_SVH
`define RXC_CONSTS_SVH
`define RXC_OFS_FILT_BW      8'h10
`define RXC_OFS_CENTRE_PA    8'h11
`define RXC_OFS_RECOG        8'h12
`define RXC_OFS_FLOOR_THR    8'h13
`define RXC_OFS_STRENGTH     8'h14
`define RXC_OFS_OOK_PEAK     8'h15
`define RXC_OFS_SYNC_FIRST   8'h16
`define RXC_RST_FILT_BW      8'hA3
`define RXC_RST_CENTRE_PA    8'h38
`define RXC_RST_RECOG        8'h18
`define RXC_RST_FLOOR_THR    8'h0C
`define RXC_RST_STRENGTH     8'h00
`define RXC_RST_OOK_PEAK     8'h00
`define RXC_RST_SYNC         8'h00
`define RXC_MASK_CENTRE_PA   8'hF8
`define RXC_MASK_RECOG       8'hFE
`define RXC_BIT_PA_STEP      3
`define RXC_BIT_POLY_EN      7
`define RXC_BIT_CLK_OFF      6
`define RXC_BIT_RECOG_EN     5
`define RXC_XTAL_REF_KHZ     12800
`define RXC_CENTRE_BASE_KHZ  200
`endif

// file: logic/rxc_pkg.sv
// types for the receiver configuration register bank
package rxc_pkg;
  typedef enum logic [1:0] {
    RXC_SYNC_1B,
    RXC_SYNC_2B,
    RXC_SYNC_3B,
    RXC_SYNC_4B
  } rxc_sync_len_t;
endpackage : rxc_pkg

// file: logic/rxc_sync_mem.sv
// start pattern byte store, registered read data
`timescale 1ns/1ps
module rxc_sync_mem #(
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // write port
  input  wire logic             i_we,
  input  wire logic [1:0]       i_waddr,
  input  wire logic [7:0]       i_wdata,
  // read port
  input  wire logic [1:0]       i_raddr,
  output logic      [7:0]       o_rdata,
  // all bytes, first byte in the top lane
  output logic      [8*DEPTH-1:0] o_pattern
);
  if (DEPTH != 4)
  begin : g_bad_depth
    $error("rxc_sync_mem: DEPTH must be 4");
  end
  logic [7:0] mem_reg [DEPTH];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_byte
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
          mem_reg[g] <= 8'h00;
        else if (i_we && i_waddr == 2'(g))
          mem_reg[g] <= i_wdata;
      end
      // byte 0 is sent first, so it sits highest
      assign o_pattern[8*(DEPTH-g)-1 -: 8] = mem_reg[g];
    end
  endgenerate
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else
      o_rdata <= mem_reg[i_raddr];
  end
endmodule : rxc_sync_mem

// file: logic/rxc_regs.sv
// receiver configuration register bank with decoded control outputs
`timescale 1ns/1ps
`include "rxc_consts.svh"
module rxc_regs
  import rxc_pkg::*;
#(
  parameter int XTAL_KHZ = 12800
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // measured signal strength from the receive path
  input  wire logic [7:0]  i_strength,
  input  wire logic        i_strength_valid,
  // receive path controls
  output logic      [3:0]  o_lowpass_bw,
  output logic      [3:0]  o_bandpass_bw,
  output logic      [3:0]  o_centre_code,
  output logic      [15:0] o_centre_khz,
  output logic             o_pa_step_regulation_en,
  output logic             o_poly_en,
  output logic             o_clock_recovery_off,
  output logic             o_recovery_run,
  output logic             o_recog_en,
  output logic      [1:0]  o_sync_length_sel,
  output logic      [2:0]  o_sync_bytes,
  output logic      [1:0]  o_sync_tolerance,
  output logic      [31:0] o_sync_pattern,
  output logic      [31:0] o_sync_mask,
  output logic      [7:0]  o_sync_byte_first,
  output logic      [7:0]  o_onoff_floor_threshold,
  output logic      [10:0] o_onoff_floor_tenth_db,
  output logic      [2:0]  o_onoff_peak_decay_step,
  output logic      [6:0]  o_decay_tenth_db,
  output logic      [2:0]  o_onoff_peak_update_rate,
  output logic             o_update_fast,
  output logic      [4:0]  o_update_factor,
  output logic      [1:0]  o_onoff_average_cutoff_sel,
  output logic      [5:0]  o_cutoff_divisor
);
  if (XTAL_KHZ < 1 || XTAL_KHZ > 65535)
  begin : g_bad_xtal
    $error("rxc_regs: XTAL_KHZ out of range");
  end

  logic [7:0] filt_bw_reg;
  logic [7:0] centre_pa_step_regulation_en;
  logic [7:0] recog_reg;
  logic [7:0] floor_thr_reg;
  logic [7:0] strength_reg;
  logic [7:0] ook_peak_reg;
  logic [7:0] rdata_next;
  logic       rd_sync_reg;
  logic [7:0] sync_rdata;
  logic       sync_hit;
  logic [7:0] sync_ofs;

  assign sync_ofs = i_addr - `RXC_OFS_SYNC_FIRST;
  assign sync_hit = i_addr >= `RXC_OFS_SYNC_FIRST && sync_ofs < 8'h04;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      filt_bw_reg <= `RXC_RST_FILT_BW;
    else if (i_wr && i_addr == `RXC_OFS_FILT_BW)
      filt_bw_reg <= i_wdata;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      centre_pa_step_regulation_en <= `RXC_RST_CENTRE_PA;
    else if (i_wr && i_addr == `RXC_OFS_CENTRE_PA)
      centre_pa_step_regulation_en <= i_wdata & `RXC_MASK_CENTRE_PA;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      recog_reg <= `RXC_RST_RECOG;
    else if (i_wr && i_addr == `RXC_OFS_RECOG)
      recog_reg <= i_wdata & `RXC_MASK_RECOG;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      floor_thr_reg <= `RXC_RST_FLOOR_THR;
    else if (i_wr && i_addr == `RXC_OFS_FLOOR_THR)
      floor_thr_reg <= i_wdata;
  end

  // software writes never reach the strength value
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      strength_reg <= `RXC_RST_STRENGTH;
    else if (i_strength_valid)
      strength_reg <= i_strength;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ook_peak_reg <= `RXC_RST_OOK_PEAK;
    else if (i_wr && i_addr == `RXC_OFS_OOK_PEAK)
      ook_peak_reg <= i_wdata;
  end

  rxc_sync_mem #(
    .DEPTH (4)
  ) u_sync (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_we      (i_wr && sync_hit),
    .i_waddr   (sync_ofs[1:0]),
    .i_wdata   (i_wdata),
    .i_raddr   (sync_ofs[1:0]),
    .o_rdata   (sync_rdata),
    .o_pattern (o_sync_pattern)
  );

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_next = 8'h00;
    case (i_addr)
      `RXC_OFS_FILT_BW:    rdata_next = filt_bw_reg;
      `RXC_OFS_CENTRE_PA:  rdata_next = centre_pa_step_regulation_en;
      `RXC_OFS_RECOG:      rdata_next = recog_reg;
      `RXC_OFS_FLOOR_THR:  rdata_next = floor_thr_reg;
      `RXC_OFS_STRENGTH:   rdata_next = strength_reg;
      `RXC_OFS_OOK_PEAK:   rdata_next = ook_peak_reg;
      default:             rdata_next = 8'h00;
    endcase
  end

  logic [7:0] rdata_reg;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_reg   <= 8'h00;
      rd_sync_reg <= 1'b0;
    end
    else
    begin
      rdata_reg   <= i_rd ? rdata_next : 8'h00;
      rd_sync_reg <= i_rd && sync_hit;
    end
  end
  // pattern bytes come from the memory's own output register
  assign o_rdata = rd_sync_reg ? sync_rdata : rdata_reg;

  assign o_lowpass_bw  = filt_bw_reg[7:4];
  assign o_bandpass_bw = filt_bw_reg[3:0];

  // centre kHz = 200 * (xtal/12800) * (L+1)/8
  logic [31:0] centre_calc;
  assign centre_calc = (32'(`RXC_CENTRE_BASE_KHZ) * 32'(XTAL_KHZ)
                        * (32'(centre_pa_step_regulation_en[7:4]) + 32'd1))
                       / (32'(`RXC_XTAL_REF_KHZ) * 32'd8);
  assign o_centre_code = centre_pa_step_regulation_en[7:4];
  assign o_centre_khz  = centre_calc[15:0];
  assign o_pa_step_regulation_en = centre_pa_step_regulation_en[`RXC_BIT_PA_STEP];

  assign o_poly_en            = recog_reg[`RXC_BIT_POLY_EN];
  assign o_clock_recovery_off = recog_reg[`RXC_BIT_CLK_OFF];
  assign o_recovery_run       = ~recog_reg[`RXC_BIT_CLK_OFF];
  assign o_recog_en           = recog_reg[`RXC_BIT_RECOG_EN];
  assign o_sync_length_sel    = recog_reg[4:3];
  assign o_sync_bytes         = {1'b0, recog_reg[4:3]} + 3'd1;
  assign o_sync_tolerance     = recog_reg[2:1];

  // mask keeps the top bytes: first byte always, more as length grows
  always_comb
  begin
    case (rxc_sync_len_t'(recog_reg[4:3]))
      RXC_SYNC_1B: o_sync_mask = 32'hFF000000;
      RXC_SYNC_2B: o_sync_mask = 32'hFFFF0000;
      RXC_SYNC_3B: o_sync_mask = 32'hFFFFFF00;
      RXC_SYNC_4B: o_sync_mask = 32'hFFFFFFFF;
      default:     o_sync_mask = 32'hFF000000;
    endcase
  end
  assign o_sync_byte_first = o_sync_pattern[31:24];

  assign o_onoff_floor_threshold = floor_thr_reg;
  // tenths of dB: code * 5, full code FFh needs eleven bits
  assign o_onoff_floor_tenth_db  = 11'(floor_thr_reg) * 11'd5;

  assign o_onoff_peak_decay_step = ook_peak_reg[7:5];
  always_comb
  begin
    case (ook_peak_reg[7:5])
      3'h0:    o_decay_tenth_db = 7'd5;
      3'h1:    o_decay_tenth_db = 7'd10;
      3'h2:    o_decay_tenth_db = 7'd15;
      3'h3:    o_decay_tenth_db = 7'd20;
      3'h4:    o_decay_tenth_db = 7'd30;
      3'h5:    o_decay_tenth_db = 7'd40;
      3'h6:    o_decay_tenth_db = 7'd50;
      default: o_decay_tenth_db = 7'd60;
    endcase
  end

  // slow codes: once per 2^n chips; fast codes: 2^(n+1) per chip
  assign o_onoff_peak_update_rate = ook_peak_reg[4:2];
  assign o_update_fast   = ook_peak_reg[4];
  assign o_update_factor = ook_peak_reg[4]
                         ? 5'(5'd2 << ook_peak_reg[3:2])
                         : 5'(5'd1 << ook_peak_reg[3:2]);

  assign o_onoff_average_cutoff_sel = ook_peak_reg[1:0];
  always_comb
  begin
    case (ook_peak_reg[1:0])
      2'h0:    o_cutoff_divisor = 6'd32;
      2'h1:    o_cutoff_divisor = 6'd8;
      2'h2:    o_cutoff_divisor = 6'd4;
      default: o_cutoff_divisor = 6'd2;
    endcase
  end

  // checks
  a_recog_unused_zero: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) recog_reg[0] == 1'b0)
    else $error("recognition unused bit set");
  a_centre_unused_zero: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) centre_pa_step_regulation_en[2:0] == 3'h0)
    else $error("centre unused bits set");
  a_centre_write_takes: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) i_wr && i_addr == `RXC_OFS_CENTRE_PA
    |=> o_centre_code == $past(i_wdata[7:4]))
    else $error("centre code not written");
  a_pa_follows_write: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) i_wr && i_addr == `RXC_OFS_CENTRE_PA
    |=> o_pa_step_regulation_en == $past(i_wdata[3]))
    else $error("regulation bit wrong");
  a_poly_follows_write: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) i_wr && i_addr == `RXC_OFS_RECOG
    |=> o_poly_en == $past(i_wdata[7]))
    else $error("polyphase enable wrong");
  a_recovery_inverted: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) i_wr && i_addr == `RXC_OFS_RECOG
    |=> o_recovery_run == !$past(i_wdata[6]))
    else $error("recovery sense wrong");
  a_recog_follows: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) i_wr && i_addr == `RXC_OFS_RECOG
    |=> o_recog_en == $past(i_wdata[5]))
    else $error("recognition enable wrong");
  a_sync_len_tol: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) i_wr && i_addr == `RXC_OFS_RECOG
    |=> o_sync_bytes == {1'b0, $past(i_wdata[4:3])} + 3'd1
        && o_sync_tolerance == $past(i_wdata[2:1]))
    else $error("pattern length or tolerance wrong");
  a_strength_ro: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) !i_strength_valid |=> $stable(strength_reg))
    else $error("strength changed without update");
  a_cutoff_map: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) ook_peak_reg[1:0] == 2'h0
    |-> o_cutoff_divisor == 6'd32)
    else $error("cutoff divisor wrong");
  a_read_thresh: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    i_rd && i_addr == `RXC_OFS_FLOOR_THR && !i_wr
    |=> o_rdata == $past(floor_thr_reg))
    else $error("threshold readback wrong");
  // maps restated in a second form so a slip in one table shows
  a_cutoff_full: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    o_cutoff_divisor == (ook_peak_reg[1:0] == 2'h0 ? 6'd32
                         : 6'd16 >> ook_peak_reg[1:0]))
    else $error("cutoff divisor table wrong");
  a_decay_map: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    o_decay_tenth_db == (ook_peak_reg[7]
      ? 7'd10 * (7'(ook_peak_reg[6:5]) + 7'd3)
      : 7'd5 * (7'(ook_peak_reg[6:5]) + 7'd1)))
    else $error("decay step table wrong");
  a_update_shape: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    $onehot(o_update_factor)
    && o_update_factor[0] == (ook_peak_reg[4:2] == 3'h0)
    && o_update_factor[4] == (ook_peak_reg[4:2] == 3'h7)
    && o_update_fast == ook_peak_reg[4])
    else $error("update rate decode wrong");
  a_strength_load: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    i_strength_valid |=> strength_reg == $past(i_strength))
    else $error("strength not loaded");
  a_first_byte_write: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    i_wr && i_addr == `RXC_OFS_SYNC_FIRST
    |=> o_sync_byte_first == $past(i_wdata))
    else $error("first pattern byte not written");
  a_first_byte_read: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    i_rd && !i_wr && i_addr == `RXC_OFS_SYNC_FIRST
    |=> o_rdata == $past(o_sync_byte_first))
    else $error("first pattern byte readback wrong");
  a_mask_top_byte: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    o_sync_mask[31:24] == 8'hFF
    && o_sync_mask[7:0] == {8{recog_reg[4:3] == 2'h3}})
    else $error("pattern mask wrong");
  a_unmapped_read: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    i_rd && !sync_hit
    && (i_addr < `RXC_OFS_FILT_BW || i_addr > `RXC_OFS_OOK_PEAK)
    |=> o_rdata == 8'h00)
    else $error("unmapped address read nonzero");

  c_recog_write: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    i_wr && i_addr == `RXC_OFS_RECOG);
  c_sync_read: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rd && sync_hit);
  c_strength_upd: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    i_strength_valid && i_strength != 8'h00);
  c_fast_update: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    o_update_fast);
  c_four_byte_pattern: cover property (@(posedge i_clock)
    disable iff (!i_rst_n) o_sync_bytes == 3'd4 && o_recog_en);
endmodule : rxc_regs

// file: dv/test_rxc_regs.sv
// self-checking bench for the receiver configuration register bank
`timescale 1ns/1ps
`include "rxc_consts.svh"
module test_rxc_regs;
  import rxc_pkg::*;

  logic        i_clock;
  logic        i_rst_n;
  logic [7:0]  i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [7:0]  i_strength;
  logic        i_strength_valid;
  logic [7:0]  o_rdata;
  logic [3:0]  o_lowpass_bw;
  logic [3:0]  o_bandpass_bw;
  logic [3:0]  o_centre_code;
  logic [15:0] o_centre_khz;
  logic        o_pa_step_regulation_en;
  logic        o_poly_en;
  logic        o_clock_recovery_off;
  logic        o_recovery_run;
  logic        o_recog_en;
  logic [1:0]  o_sync_length_sel;
  logic [2:0]  o_sync_bytes;
  logic [1:0]  o_sync_tolerance;
  logic [31:0] o_sync_pattern;
  logic [31:0] o_sync_mask;
  logic [7:0]  o_sync_byte_first;
  logic [7:0]  o_onoff_floor_threshold;
  logic [10:0] o_onoff_floor_tenth_db;
  logic [2:0]  o_onoff_peak_decay_step;
  logic [6:0]  o_decay_tenth_db;
  logic [2:0]  o_onoff_peak_update_rate;
  logic        o_update_fast;
  logic [4:0]  o_update_factor;
  logic [1:0]  o_onoff_average_cutoff_sel;
  logic [5:0]  o_cutoff_divisor;
  int          n_errors;
  int          samples_checked;
  int          cycles;

  rxc_regs i_rxc_regs (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_strength(i_strength), .i_strength_valid(i_strength_valid),
    .o_lowpass_bw(o_lowpass_bw), .o_bandpass_bw(o_bandpass_bw),
    .o_centre_code(o_centre_code),
    .o_centre_khz(o_centre_khz),
    .o_pa_step_regulation_en(o_pa_step_regulation_en),
    .o_poly_en(o_poly_en), .o_clock_recovery_off(o_clock_recovery_off),
    .o_recovery_run(o_recovery_run), .o_recog_en(o_recog_en),
    .o_sync_length_sel(o_sync_length_sel), .o_sync_bytes(o_sync_bytes),
    .o_sync_tolerance(o_sync_tolerance), .o_sync_pattern(o_sync_pattern),
    .o_sync_mask(o_sync_mask), .o_sync_byte_first(o_sync_byte_first),
    .o_onoff_floor_threshold(o_onoff_floor_threshold),
    .o_onoff_floor_tenth_db(o_onoff_floor_tenth_db),
    .o_onoff_peak_decay_step(o_onoff_peak_decay_step),
    .o_decay_tenth_db(o_decay_tenth_db),
    .o_onoff_peak_update_rate(o_onoff_peak_update_rate),
    .o_update_fast(o_update_fast), .o_update_factor(o_update_factor),
    .o_onoff_average_cutoff_sel(o_onoff_average_cutoff_sel),
    .o_cutoff_divisor(o_cutoff_divisor)
  );

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // strobe for one cycle; results are looked at 1 ns after the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rd

  task automatic test_reset_values;
    rd(8'h10, 8'hA3);
    chk({o_lowpass_bw, o_bandpass_bw}, 32'hA3);
    rd(8'h11, 8'h38);
    rd(8'h12, 8'h18);
    rd(8'h13, 8'h0C);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    chk(o_centre_khz, 32'd100);
    chk(o_onoff_floor_tenth_db, 32'd60);
    chk(o_sync_bytes, 32'd4);
  endtask : test_reset_values

  task automatic test_centre;
    wr(8'h11, 8'hFF);
    chk({o_centre_code, o_pa_step_regulation_en}, 32'h1F);
    chk(o_centre_khz, 32'd400);
    rd(8'h11, 8'hF8);
    wr(8'h11, 8'h07);
    chk(o_pa_step_regulation_en, 32'd0);
    chk(o_centre_khz, 32'd25);
    rd(8'h11, 8'h00);
  endtask : test_centre

  task automatic test_recog;
    wr(8'h12, 8'hE6);
    chk({o_poly_en, o_clock_recovery_off, o_recovery_run}, 32'h6);
    chk({o_recog_en, o_sync_length_sel, o_sync_tolerance}, 32'h13);
    chk(o_sync_bytes, 32'd1);
    wr(8'h12, 8'h19);
    chk({o_poly_en, o_recovery_run, o_recog_en}, 32'h2);
    chk({o_sync_bytes, o_sync_tolerance}, 32'h10);
    rd(8'h12, 8'h18);
  endtask : test_recog

  task automatic test_threshold;
    wr(8'h13, 8'hFF);
    chk(o_onoff_floor_threshold, 32'hFF);
    chk(o_onoff_floor_tenth_db, 32'd1275);
    rd(8'h13, 8'hFF);
    wr(8'h10, 8'h5C);
    chk({o_lowpass_bw, o_bandpass_bw}, 32'h5C);
    rd(8'h10, 8'h5C);
  endtask : test_threshold

  task automatic test_peak;
    int dec[8];
    int div[4];
    logic [7:0] v;
    dec = '{5, 10, 15, 20, 30, 40, 50, 60};
    div = '{32, 8, 4, 2};
    for (int i = 0; i < 8; i++)
    begin
      v = {i[2:0], i[2:0], i[1:0]};
      wr(8'h15, v);
      chk(o_onoff_peak_decay_step, i);
      chk(o_decay_tenth_db, dec[i]);
      chk(o_update_fast, i[2]);
      chk(o_update_factor, (i[2] ? 2 : 1) << i[1:0]);
      chk(o_onoff_average_cutoff_sel, i[1:0]);
      chk(o_cutoff_divisor, div[i[1:0]]);
      rd(8'h15, v);
    end
  endtask : test_peak

  task automatic test_strength;
    wr(8'h14, 8'h5A);
    rd(8'h14, 8'h00);
    @(posedge i_clock);
    i_strength       <= 8'h9C;
    i_strength_valid <= 1'b1;
    @(posedge i_clock);
    i_strength_valid <= 1'b0;
    i_strength       <= 8'h00;
    rd(8'h14, 8'h9C);
    wr(8'hF0, 8'hFF);
    rd(8'hF0, 8'h00);
  endtask : test_strength

  task automatic test_pattern;
    wr(8'h16, 8'hC1);
    wr(8'h17, 8'h52);
    wr(8'h18, 8'h63);
    wr(8'h19, 8'h74);
    chk(o_sync_pattern, 32'hC1526374);
    chk(o_sync_byte_first, 32'hC1);
    rd(8'h16, 8'hC1);
    rd(8'h19, 8'h74);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h12, {3'b001, s[1:0], 3'b000});
      chk(o_sync_mask, ~(32'hFFFFFFFF >> (8 * (s + 1))));
    end
  endtask : test_pattern

  task automatic final_report;
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // whole run needs well under 1000 cycles
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      final_report();
    end
  end

  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    i_rst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_strength = 8'h00;
    i_strength_valid = 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    test_reset_values();
    test_centre();
    test_recog();
    test_threshold();
    test_peak();
    test_strength();
    test_pattern();
    final_report();
  end
endmodule : test_rxc_regs
